// ==== rtl/line_codec_defs.vh ====
// constants and timing for the manchester line codec
`ifndef LINE_CODEC_DEFS_VH
`define LINE_CODEC_DEFS_VH

// system clock rate
`define CLK_MHZ          25
// bit time of the link
`define BIT_NS           100
// longest gap after the last bit before end of frame is flagged
`define EOF_NS           150
// blanking after a mid-cell edge, three quarters of a bit
`define BLANK_NS         75
// collision indication hold after the last collision pair edge
`define COL_HOLD_NS      200
// half cells of forced high after the last bit before idle
`define END_HALVES       2
// counter width for all timing counters
`define CNT_W            4

`endif

// ==== rtl/manchester_line_codec.v ====
// manchester encoder, decoder, collision translator and clock divider
`include "line_codec_defs.vh"

module manchester_line_codec #(
    parameter EOF_CYC   = (`EOF_NS * `CLK_MHZ) / 1000,
    parameter BLANK_CYC = (`BLANK_NS * `CLK_MHZ) / 1000,
    parameter COL_CYC   = (`COL_HOLD_NS * `CLK_MHZ) / 1000
) (
    // clock, reset, enable
    input  wire clk_i,
    input  wire resetn_i,
    input  wire ce_i,

    // straps
    input  wire codec_bypass_select_i,
    input  wire idle_level_select_i,

    // oscillator
    input  wire oscillator_input_i,
    output reg  oscillator_feedback_output_o,
    output reg  transmit_bit_clock_o,

    // mac transmit side
    input  wire mac_tx_en_i,
    input  wire mac_tx_data_i,
    output reg  mac_retry_request_o,

    // mac receive side
    output reg  mac_rx_data_o,
    output reg  mac_rx_clock_o,
    output reg  mac_rx_active_o,
    output reg  mac_rx_end_o,
    output reg  mac_collision_o,

    // transmit pair
    output reg  tx_pair_pos_o,
    output reg  tx_pair_neg_o,

    // receive pair, as comparator level plus squelch qualification
    input  wire rx_pair_level_i,
    input  wire rx_squelch_ok_i,

    // collision pair
    input  wire collision_pair_pos_i,
    input  wire collision_pair_neg_i,
    input  wire collision_squelch_ok_i,

    // external codec pins
    output reg  ext_tx_en_o,
    output reg  ext_tx_data_o,
    input  wire ext_rx_data_i,
    input  wire ext_rx_clock_i,
    input  wire ext_rx_active_i,
    input  wire ext_collision_i
);

    // one-hot encoder states: idle, sending cells, forced high tail
    localparam [2:0] S_IDLE = 3'b001;
    localparam [2:0] S_DATA = 3'b010;
    localparam [2:0] S_ENDH = 3'b100;

    function [`CNT_W-1:0] cnt_of;
        input integer c;
        begin
            cnt_of = (c < 1) ? {{(`CNT_W-1){1'b0}}, 1'b1} : c[`CNT_W-1:0];
        end
    endfunction

    // one step down for the timing counters, callers keep them from wrapping
    function [`CNT_W-1:0] dec1;
        input [`CNT_W-1:0] v;
        begin
            dec1 = v - {{(`CNT_W-1){1'b0}}, 1'b1};
        end
    endfunction

    function is_one;
        input [`CNT_W-1:0] v;
        begin
            is_one = (v == {{(`CNT_W-1){1'b0}}, 1'b1});
        end
    endfunction

    function is_zero;
        input [`CNT_W-1:0] v;
        begin
            is_zero = (v == {`CNT_W{1'b0}});
        end
    endfunction

    // oscillator edge detect, each rising edge is one half bit cell
    reg               osc_prev_q;
    wire              half_tick = oscillator_input_i & ~osc_prev_q;

    // encoder state
    reg  [2:0]        tx_state_q;
    reg               phase_q;
    reg               bit_q;
    reg               line_q;
    reg               abort_q;
    reg  [`CNT_W-1:0] end_cnt_q;

    // decoder state
    reg               rx_prev_q;
    reg               rx_run_q;
    reg  [`CNT_W-1:0] blank_q;
    reg  [`CNT_W-1:0] gap_q;
    reg               int_rx_data_q;
    reg               int_rx_clk_q;

    // collision state
    reg               cd_prev_q;
    reg  [`CNT_W-1:0] cd_hold_q;

    wire rx_edge = rx_pair_level_i ^ rx_prev_q;
    wire cd_diff = collision_pair_pos_i & ~collision_pair_neg_i;
    wire cd_edge = collision_squelch_ok_i & (cd_diff ^ cd_prev_q);
    wire col_now = codec_bypass_select_i ? ext_collision_i : ~is_zero(cd_hold_q);

    // encoder decode: a frame only starts on a cell boundary so its first half is never cut short
    wire cell_start = half_tick & ~phase_q;
    wire tx_start   = cell_start & mac_tx_en_i & ~codec_bypass_select_i;
    wire tx_stop    = ~mac_tx_en_i | abort_q | col_now;

    // decoder decode: an edge counts as mid-cell only once the blanking window has run out
    wire blank_idle = is_zero(blank_q);
    wire rx_take    = rx_edge & blank_idle;

    // clock divider: the oscillator is sampled, each seen rising edge is one half bit cell
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            osc_prev_q                   <= 1'b0;
            oscillator_feedback_output_o <= 1'b1;
            transmit_bit_clock_o         <= 1'b0;
            phase_q                      <= 1'b0;
        end else if (ce_i) begin
            osc_prev_q                   <= oscillator_input_i;
            oscillator_feedback_output_o <= ~oscillator_input_i;
            if (half_tick) begin
                phase_q              <= ~phase_q;
                transmit_bit_clock_o <= phase_q;
            end
        end
    end // clock divider

    // external codec pins always follow the mac, whichever codec is selected
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ext_tx_en_o   <= 1'b0;
            ext_tx_data_o <= 1'b0;
        end else if (ce_i) begin
            ext_tx_en_o   <= mac_tx_en_i;
            ext_tx_data_o <= mac_tx_data_i;
        end
    end // external codec pins

    // encoder
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_state_q          <= S_IDLE;
            bit_q               <= 1'b0;
            line_q              <= 1'b1;
            abort_q             <= 1'b0;
            end_cnt_q           <= {`CNT_W{1'b0}};
            mac_retry_request_o <= 1'b0;
        end else if (ce_i) begin
            mac_retry_request_o <= 1'b0;
            // abort is latched so a collision between cell boundaries is not missed
            if (tx_state_q == S_DATA && col_now && !abort_q) begin
                abort_q             <= 1'b1;
                mac_retry_request_o <= 1'b1;
            end
            // the state only moves on a half cell, the clocks in between just hold it
            if (half_tick) begin
                case (tx_state_q)
                    S_IDLE: begin
                        abort_q <= 1'b0;
                        if (tx_start) begin
                            bit_q      <= mac_tx_data_i;
                            line_q     <= ~mac_tx_data_i;
                            tx_state_q <= S_DATA;
                        end
                    end
                    S_DATA: begin
                        if (phase_q) begin
                            line_q <= bit_q;
                        end else if (tx_stop) begin
                            // a closing zero rises here, a closing one is already high
                            line_q     <= 1'b1;
                            end_cnt_q  <= cnt_of(`END_HALVES);
                            tx_state_q <= S_ENDH;
                        end else begin
                            bit_q  <= mac_tx_data_i;
                            line_q <= ~mac_tx_data_i;
                        end
                    end
                    S_ENDH: begin
                        if (is_one(end_cnt_q)) begin
                            tx_state_q <= S_IDLE;
                        end
                        end_cnt_q <= dec1(end_cnt_q);
                    end
                    default: begin
                        tx_state_q <= S_IDLE;
                    end
                endcase
            end
        end
    end // encoder

    // transmit pair drive
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_pair_pos_o <= 1'b0;
            tx_pair_neg_o <= 1'b0;
        end else if (ce_i) begin
            // the pair shows the line only outside idle, the idle level comes from the strap
            if (tx_state_q == S_IDLE) begin
                tx_pair_pos_o <= ~idle_level_select_i;
                tx_pair_neg_o <= 1'b0;
            end else begin
                tx_pair_pos_o <= line_q;
                tx_pair_neg_o <= ~line_q;
            end
        end
    end // transmit pair drive

    // decoder: a qualified edge after the blanking window is a mid-cell edge
    // sampling at the system clock leaves little margin, the blanking count trades jitter tolerance for it
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_prev_q     <= 1'b0;
            rx_run_q      <= 1'b0;
            blank_q       <= {`CNT_W{1'b0}};
            gap_q         <= {`CNT_W{1'b0}};
            int_rx_data_q <= 1'b0;
            int_rx_clk_q  <= 1'b0;
            mac_rx_end_o  <= 1'b0;
        end else if (ce_i) begin
            rx_prev_q    <= rx_pair_level_i;
            int_rx_clk_q <= 1'b0;
            mac_rx_end_o <= 1'b0;
            if (!blank_idle) begin
                blank_q <= dec1(blank_q);
            end
            // squelch loss closes a frame in progress, so a dropped carrier still gives an end pulse
            if (!rx_squelch_ok_i) begin
                rx_run_q      <= 1'b0;
                int_rx_data_q <= 1'b0;
                if (rx_run_q) begin
                    mac_rx_end_o <= 1'b1;
                end
            end else if (rx_take) begin
                rx_run_q      <= 1'b1;
                int_rx_data_q <= rx_pair_level_i;
                int_rx_clk_q  <= 1'b1;
                blank_q       <= cnt_of(BLANK_CYC);
                gap_q         <= cnt_of(EOF_CYC);
            end else if (rx_run_q) begin
                if (is_one(gap_q)) begin
                    rx_run_q      <= 1'b0;
                    int_rx_data_q <= 1'b0;
                    mac_rx_end_o  <= 1'b1;
                end
                gap_q <= dec1(gap_q);
            end
        end
    end // decoder

    // collision translator
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cd_prev_q <= 1'b0;
            cd_hold_q <= {`CNT_W{1'b0}};
        end else if (ce_i) begin
            cd_prev_q <= cd_diff;
            // every qualified edge re-arms the hold, so a 10 mhz burst reads as one steady level
            if (cd_edge) begin
                cd_hold_q <= cnt_of(COL_CYC);
            end else if (!is_zero(cd_hold_q)) begin
                cd_hold_q <= dec1(cd_hold_q);
            end
        end
    end // collision translator

    // mac side receive outputs, selected by bypass
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mac_rx_data_o   <= 1'b0;
            mac_rx_clock_o  <= 1'b0;
            mac_rx_active_o <= 1'b0;
            mac_collision_o <= 1'b0;
        end else if (ce_i) begin
            mac_collision_o <= col_now;
            // squelch is applied again here so outside bypass the mac never sees unqualified data
            if (codec_bypass_select_i) begin
                mac_rx_data_o   <= ext_rx_data_i;
                mac_rx_clock_o  <= ext_rx_clock_i;
                mac_rx_active_o <= ext_rx_active_i;
            end else begin
                mac_rx_data_o   <= int_rx_data_q & rx_squelch_ok_i;
                mac_rx_clock_o  <= int_rx_clk_q;
                mac_rx_active_o <= rx_run_q & rx_squelch_ok_i;
            end
        end
    end // mac side receive outputs

endmodule // manchester_line_codec

// ==== tb/line_codec_monitor.sv ====
// port checker for the manchester line codec
module line_codec_monitor #(parameter EOF_CYC = 3, BLANK_CYC = 1, COL_CYC = 5) (
    // clock, reset, straps, oscillator, retry request
    input wire logic clk_i, resetn_i, codec_bypass_select_i, idle_level_select_i, oscillator_input_i,
    input wire logic oscillator_feedback_output_o, transmit_bit_clock_o, mac_retry_request_o,
    // transmit side
    input wire logic mac_tx_en_i, mac_tx_data_i, ext_tx_en_o, ext_tx_data_o, tx_pair_pos_o, tx_pair_neg_o,
    // receive and collision side
    input wire logic rx_squelch_ok_i, mac_rx_data_o, mac_rx_clock_o, mac_rx_active_o, mac_rx_end_o,
    input wire logic collision_pair_pos_i, collision_pair_neg_i, collision_squelch_ok_i, mac_collision_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    wire logic byp = codec_bypass_select_i;
    wire logic col = collision_pair_pos_i & !collision_pair_neg_i;
    property p_fb; $past(resetn_i) |-> oscillator_feedback_output_o == !$past(oscillator_input_i); endproperty
    a_fb: assert property (p_fb) else $error("feedback not inverse of oscillator");
    // a toggle only after a sampled rising oscillator edge keeps the bit clock at half rate
    property p_txc; $past(resetn_i, 2) && $changed(transmit_bit_clock_o)
        |-> $past(oscillator_input_i) && !$past(oscillator_input_i, 2); endproperty
    a_txc: assert property (p_txc) else $error("bit clock toggled without oscillator edge");
    property p_idle; $past(resetn_i) && !tx_pair_pos_o && !tx_pair_neg_o
        |-> $past(idle_level_select_i) || $past(idle_level_select_i, 2); endproperty
    a_idle: assert property (p_idle) else $error("pair equal while idle select low");
    property p_sq; $past(resetn_i) && !$past(byp) && !byp && !$past(rx_squelch_ok_i)
        |-> !mac_rx_active_o && !mac_rx_data_o; endproperty
    a_sq: assert property (p_sq) else $error("receive outputs active without squelch");
    property p_start; !byp && !$past(byp) && (mac_rx_clock_o || $rose(mac_rx_active_o))
        |-> $past(rx_squelch_ok_i); endproperty
    a_start: assert property (p_start) else $error("decoding on unqualified input");
    property p_eof; !byp && mac_rx_clock_o ##1 !mac_rx_clock_o [*5] |-> !mac_rx_active_o; endproperty
    a_eof: assert property (p_eof) else $error("end of frame not detected in time");
    property p_col; !byp && collision_squelch_ok_i && $rose(col) |-> ##[1:2] mac_collision_o; endproperty
    a_col: assert property (p_col) else $error("collision activity not indicated");
    property p_retry; mac_retry_request_o |-> ##[0:2] mac_collision_o; endproperty
    a_retry: assert property (p_retry) else $error("retry without collision");
    property p_ext; $past(resetn_i) |-> ext_tx_en_o == $past(mac_tx_en_i) && ext_tx_data_o == $past(mac_tx_data_i);
    endproperty
    a_ext: assert property (p_ext) else $error("external codec pins not following mac");
    c_end: cover property (mac_rx_end_o);
    c_retry: cover property (mac_retry_request_o);
    c_byp: cover property (byp && mac_collision_o);
endmodule // line_codec_monitor

bind manchester_line_codec line_codec_monitor #(.EOF_CYC(EOF_CYC), .BLANK_CYC(BLANK_CYC), .COL_CYC(COL_CYC))
    u_mon (.*);

// ==== tb/line_partner.sv ====
// far-side transceiver model: receive stream, squelch and collision signalling
module line_partner (
    // clock
    input  wire logic clk_i,
    // pair levels toward the codec
    output logic      rx_pair_level_i, rx_squelch_ok_i,
    output logic      collision_pair_pos_i, collision_pair_neg_i, collision_squelch_ok_i
);
    timeunit 1ns;
    timeprecision 1ps;
    bit busy = 0;
    initial {rx_pair_level_i, rx_squelch_ok_i, collision_pair_pos_i, collision_pair_neg_i, collision_squelch_ok_i} = 0;
    // released lines keep changing so a stale level never looks like valid data
    always @(negedge clk_i) if (!busy) begin
        rx_pair_level_i <= !rx_pair_level_i;
        collision_pair_pos_i <= !collision_pair_pos_i;
        collision_pair_neg_i <= !collision_pair_pos_i;
    end
    // one half cell per clock; squelch is met only around the frame
    task automatic send(input logic [31:0] b, input int n);
        busy = 1;
        @(negedge clk_i) rx_pair_level_i <= !b[0];
        @(negedge clk_i) rx_squelch_ok_i <= 1;
        for (int i = 0; i < n; i++) begin
            if (i > 0) @(negedge clk_i) rx_pair_level_i <= !b[i];
            @(negedge clk_i) rx_pair_level_i <= b[i];
        end
        repeat (6) @(negedge clk_i);
        rx_squelch_ok_i <= 0;
        busy = 0;
    endtask
    // fastest toggle the sampled pair can show stands in for the 10 mhz burst
    task automatic collide(input int n);
        busy = 1;
        @(negedge clk_i) {collision_pair_neg_i, collision_squelch_ok_i} <= 2'b01;
        repeat (n) @(negedge clk_i) collision_pair_pos_i <= !collision_pair_pos_i;
        @(negedge clk_i) collision_squelch_ok_i <= 0;
        busy = 0;
    endtask
endmodule // line_partner

// ==== tb/test_manchester_line_codec.sv ====
// self-checking bench for the manchester line codec
module test_manchester_line_codec;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, resetn_i = 0, ce_i = 1, codec_bypass_select_i = 0, idle_level_select_i = 1;
    logic oscillator_input_i = 0, mac_tx_en_i = 0, mac_tx_data_i = 0;
    logic ext_rx_data_i = 0, ext_rx_clock_i = 0, ext_rx_active_i = 0, ext_collision_i = 0;
    wire  oscillator_feedback_output_o, transmit_bit_clock_o, mac_retry_request_o, mac_rx_data_o, mac_rx_clock_o;
    wire  mac_rx_active_o, mac_rx_end_o, mac_collision_o, tx_pair_pos_o, tx_pair_neg_o, ext_tx_en_o, ext_tx_data_o;
    wire  rx_pair_level_i, rx_squelch_ok_i, collision_pair_pos_i, collision_pair_neg_i, collision_squelch_ok_i;
    int   err_total = 0, num_checks = 0, n_retry = 0, n_col = 0, n_end = 0, j, k, n0;
    logic [31:0] seed = 32'h161a4366;
    logic l;
    bit   rxq[$];

    manchester_line_codec #(.EOF_CYC(3), .BLANK_CYC(1), .COL_CYC(5)) u_dut (.*);
    line_partner u_xcvr (.*);

    always #20 clk_i = !clk_i;
    // slower than the real oscillator, but every sampled rising edge still marks one half cell
    always @(negedge clk_i) if (resetn_i) oscillator_input_i <= !oscillator_input_i;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string nm, input logic [1:0] seen, input logic [1:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %b seen %b", nm, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // receive model: every recovered bit must match the next bit sent
    always @(negedge clk_i) begin
        n_retry += (mac_retry_request_o === 1'b1);
        n_col += (mac_collision_o === 1'b1);
        n_end += (mac_rx_end_o === 1'b1);
        if (mac_rx_clock_o === 1'b1 && codec_bypass_select_i == 0) begin
            chk("rx_unexpected", rxq.size() != 0, 1);
            chk("rx_active", mac_rx_active_o, 1);
            if (rxq.size() != 0) chk("rx_data", mac_rx_data_o, rxq.pop_front());
        end
    end

    // the cell phase is unknown, so sampling aligns on the first non-idle half cell
    task automatic tx_frame(input int n);
        seed = lfsr(seed);
        mac_tx_data_i = seed[0];
        mac_tx_en_i = 1;
        for (k = 0; k < 40 && !(tx_pair_pos_o | tx_pair_neg_o); k++) @(negedge clk_i);
        for (j = 0; j < 2 * n + 3; j++) begin
            l = (j < 2 * n) ? seed[j / 2] ^ !j[0] : 1'b1;
            chk("tx_pair", {tx_pair_pos_o, tx_pair_neg_o}, (j < 2 * n + 2) ? {l, !l} : 2'b00);
            if (j[0]) mac_tx_data_i = seed[j / 2 + 1];
            if (j == 2 * n - 1) mac_tx_en_i = 0;
            repeat (2) @(negedge clk_i);
        end
    endtask

    initial begin
        repeat (2) @(negedge clk_i);
        resetn_i = 1;
        repeat (4) @(negedge clk_i);
        tx_frame(1);
        tx_frame(9);
        mac_tx_en_i = 1;
        repeat (8) @(negedge clk_i);
        u_xcvr.collide(6);
        chk("retry_pulse", n_retry == 1, 1);
        chk("collision", n_col != 0, 1);
        mac_tx_en_i = 0;
        repeat (14) @(negedge clk_i);
        chk("abort_idle", {tx_pair_pos_o, tx_pair_neg_o}, 0);
        idle_level_select_i = 0;
        repeat (4) @(negedge clk_i);
        chk("idle_pos_high", {tx_pair_pos_o, tx_pair_neg_o}, 2'b10);
        idle_level_select_i = 1;
        for (n0 = 0; n0 < 3; n0++) begin
            seed = lfsr(seed);
            for (j = 0; j < 12; j++) rxq.push_back(seed[j]);
            k = n_end;
            u_xcvr.send(seed, 12);
            chk("rx_all_bits", rxq.size() == 0, 1);
            chk("rx_end", n_end == k + 1, 1);
        end
        codec_bypass_select_i = 1;
        {ext_rx_data_i, ext_rx_active_i, ext_collision_i, ext_rx_clock_i, mac_tx_en_i} = 5'h1f;
        repeat (6) @(negedge clk_i);
        chk("bypass_rx", {mac_rx_data_o, mac_collision_o}, 2'b11);
        chk("bypass_tx_quiet", {tx_pair_pos_o, tx_pair_neg_o}, 0);
        chk("bypass_rx_ctl", {mac_rx_clock_o, mac_rx_active_o}, 2'b11);
        chk("bypass_ext_tx_en", ext_tx_en_o, 1);
        {ext_rx_data_i, ext_rx_active_i, ext_collision_i, ext_rx_clock_i, mac_tx_en_i} = 5'h00;
        repeat (6) @(negedge clk_i);
        chk("bypass_clear", {mac_rx_data_o, mac_collision_o}, 0);
        chk("bypass_ctl_clear", {mac_rx_clock_o, mac_rx_active_o}, 0);
        codec_bypass_select_i = 0;
        repeat (4) @(negedge clk_i);
        tally_and_finish();
    end

    // the sequence needs well under a thousand cycles; this allows a wide margin
    initial begin
        #40000;
        err_total++;
        tally_and_finish();
    end
endmodule // test_manchester_line_codec
